// *** fhs_supervisor.sv ***
// fixing heater regulation and supervision
// Behaviour
// - heater on below setpoint, off above
// - standby setpoint is 165 degrees
// - printing raises setpoint to 180 degrees
// - fault unless above 30 within 18s
// - fault unless above 165 within 90s
// - fault above 230; report code 50
// - after ready, fault below 140
// - service switch closed keeps heater off
// - fault asserts heater fault drive output
`timescale 1ns/1ps
`include "fhs_consts.svh"
module fhs_supervisor #(
  parameter int SAMPLE_CYC = `FHS_SAMPLE_CYC,
  parameter int TICKS_PER_S = `FHS_TICKS_PER_S,
  parameter int WARM1_S = `FHS_WARM1_S,
  parameter int WARM2_S = `FHS_WARM2_S
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`FHS_TEMP_W-1:0] fixing_thermistor,
  input wire logic printing,
  input wire logic cover_service_switch,
  output logic heater_switch,
  output logic heater_fault_drive_n,
  output logic ready,
  output logic [7:0] status_code
);
  // ****************************************
  // input synchronisation
  // ****************************************
  logic [`FHS_TEMP_W+1:0] pins_sync;
  fhs_sync #(.WIDTH(`FHS_TEMP_W + 2)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .din({cover_service_switch, printing, fixing_thermistor}),
    .dout(pins_sync)
  );
  logic svc_closed;
  logic print_req;
  logic [`FHS_TEMP_W-1:0] temp_live;
  assign svc_closed = pins_sync[`FHS_TEMP_W+1];
  assign print_req = pins_sync[`FHS_TEMP_W];
  assign temp_live = pins_sync[`FHS_TEMP_W-1:0];

  // ****************************************
  // state
  // ****************************************
  fhs_pkg::fhs_state_t state;
  fhs_pkg::fhs_state_t next_state;
  logic [31:0] sample_cnt;
  logic [31:0] next_sample_cnt;
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic [31:0] secs;
  logic [31:0] next_secs;
  logic [`FHS_TEMP_W-1:0] temp;
  logic [`FHS_TEMP_W-1:0] next_temp;
  logic sampled;
  logic next_sampled;
  logic seen_cold;
  logic next_seen_cold;
  logic next_heater_switch;
  logic next_heater_fault_drive_n;
  logic next_ready;
  logic [7:0] next_status_code;
  logic [`FHS_TEMP_W-1:0] setpoint;
  logic sample_tick;
  logic fault_now;

  // ****************************************
  // helper functions
  // ****************************************
  // a valid sample strictly above a limit
  function automatic logic sample_above(
    input logic valid,
    input logic [`FHS_TEMP_W-1:0] value,
    input logic [`FHS_TEMP_W-1:0] limit
  );
    return valid && (value > limit);
  endfunction

  // a valid sample strictly below a limit
  function automatic logic sample_below(
    input logic valid,
    input logic [`FHS_TEMP_W-1:0] value,
    input logic [`FHS_TEMP_W-1:0] limit
  );
    return valid && (value < limit);
  endfunction

  // a free-running count has reached the end of its period
  function automatic logic period_end(
    input logic [31:0] count,
    input int period
  );
    return count >= 32'(period - 1);
  endfunction

  // ****************************************
  // sample timing
  // ****************************************
  // sample strobe, one cycle in every period
  assign sample_tick = period_end(sample_cnt, SAMPLE_CYC);

  // next values for the sample and the seconds count
  always_comb begin
    next_sample_cnt = sample_cnt + 32'h1;
    next_temp = temp;
    next_sampled = sampled;
    next_tick_cnt = tick_cnt;
    next_secs = secs;
    if (sample_tick) begin
      next_sample_cnt = 32'h0;
      next_temp = temp_live;
      next_sampled = 1'h1;
      if (period_end(tick_cnt, TICKS_PER_S)) begin
        next_tick_cnt = 32'h0;
        if (secs != 32'hffffffff) begin
          next_secs = secs + 32'h1; // saturates so a late window never reopens
        end
      end else begin
        next_tick_cnt = tick_cnt + 32'h1;
      end
    end
  end

  // timing registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sample_cnt <= 32'h0;
      tick_cnt <= 32'h0;
      secs <= 32'h0;
      temp <= '0;
      sampled <= 1'h0;
    end else begin
      sample_cnt <= next_sample_cnt;
      tick_cnt <= next_tick_cnt;
      secs <= next_secs;
      temp <= next_temp;
      sampled <= next_sampled;
    end
  end

  // ****************************************
  // supervision
  // ****************************************
  // setpoint by mode
  always_comb begin
    setpoint = print_req ? `FHS_SETPOINT_PRINT : `FHS_SETPOINT_STANDBY;
  end

  // fault conditions on the latest sample, a sample warm enough right now counts as risen
  always_comb begin
    fault_now = 1'h0;
    if (sample_above(sampled, temp, `FHS_LIMIT_OVER)) begin
      fault_now = 1'h1;
    end
    if (!seen_cold && !sample_above(sampled, temp, `FHS_LIMIT_COLD) && secs >= 32'(WARM1_S)) begin
      fault_now = 1'h1;
    end
    if (state == fhs_pkg::FHS_WARMUP && !sample_above(sampled, temp, `FHS_LIMIT_WARM)
        && secs >= 32'(WARM2_S)) begin
      fault_now = 1'h1;
    end
    if (state == fhs_pkg::FHS_READY && sample_below(sampled, temp, `FHS_LIMIT_UNDER)) begin
      fault_now = 1'h1;
    end
  end

  // next values for supervision, regulation and status
  always_comb begin
    next_seen_cold = seen_cold;
    next_state = state;
    next_heater_switch = heater_switch;
    if (sample_above(sampled, temp, `FHS_LIMIT_COLD)) begin
      next_seen_cold = 1'h1;
    end
    case (state)
      fhs_pkg::FHS_WARMUP: begin
        if (fault_now) begin
          next_state = fhs_pkg::FHS_FAULT;
        end else if (seen_cold && sample_above(sampled, temp, `FHS_LIMIT_WARM)) begin
          next_state = fhs_pkg::FHS_READY;
        end
      end
      fhs_pkg::FHS_READY: begin
        if (fault_now) begin
          next_state = fhs_pkg::FHS_FAULT;
        end
      end
      fhs_pkg::FHS_FAULT: begin
        next_state = fhs_pkg::FHS_FAULT;
      end
      default: begin
        next_state = fhs_pkg::FHS_FAULT; // unused code, fail safe
      end
    endcase
    // regulation with hold on an exact match
    if (!sampled) begin
      next_heater_switch = 1'h0; // no reading yet, stay cold
    end else if (sample_below(sampled, temp, setpoint)) begin
      next_heater_switch = 1'h1;
    end else if (sample_above(sampled, temp, setpoint)) begin
      next_heater_switch = 1'h0;
    end
    if (svc_closed) begin
      next_heater_switch = 1'h0;
    end
    if (next_state == fhs_pkg::FHS_FAULT) begin
      next_heater_switch = 1'h0;
    end
    // status outputs follow the state being entered
    next_heater_fault_drive_n = (next_state != fhs_pkg::FHS_FAULT);
    next_ready = (next_state == fhs_pkg::FHS_READY);
    if (next_state == fhs_pkg::FHS_FAULT) begin
      next_status_code = `FHS_STATUS_FIX_FAULT;
    end else begin
      next_status_code = `FHS_STATUS_OK;
    end
  end

  // supervision registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= fhs_pkg::FHS_WARMUP;
      seen_cold <= 1'h0;
      heater_switch <= 1'h0;
      heater_fault_drive_n <= 1'h1;
      ready <= 1'h0;
      status_code <= `FHS_STATUS_OK;
    end else begin
      state <= next_state;
      seen_cold <= next_seen_cold;
      heater_switch <= next_heater_switch;
      heater_fault_drive_n <= next_heater_fault_drive_n;
      ready <= next_ready;
      status_code <= next_status_code;
    end
  end
endmodule // fhs_supervisor

// *** fhs_consts.svh ***
// constants for the fixing heater supervisor
`ifndef FHS_CONSTS_SVH
`define FHS_CONSTS_SVH
`define FHS_CLK_HZ 20000000
`define FHS_TEMP_W 10
`define FHS_SETPOINT_STANDBY 10'h0a5
`define FHS_SETPOINT_PRINT 10'h0b4
`define FHS_LIMIT_COLD 10'h01e
`define FHS_LIMIT_WARM 10'h0a5
`define FHS_LIMIT_OVER 10'h0e6
`define FHS_LIMIT_UNDER 10'h08c
`define FHS_WARM1_S 18
`define FHS_WARM2_S 90
`define FHS_SAMPLE_US 1000
`define FHS_SAMPLE_CYC ((`FHS_SAMPLE_US * (`FHS_CLK_HZ / 1000000)))
`define FHS_TICKS_PER_S (1000000 / `FHS_SAMPLE_US)
`define FHS_STATUS_FIX_FAULT 8'h32
`define FHS_STATUS_OK 8'h00
`endif

// *** fhs_pkg.sv ***
// types for the fixing heater supervisor
package fhs_pkg;
  typedef enum logic [1:0] {
    FHS_WARMUP = 2'b00,
    FHS_READY = 2'b01,
    FHS_FAULT = 2'b10
  } fhs_state_t;
endpackage

// *** fhs_sync.sv ***
// two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module fhs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  // next values
  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  // two stages
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule // fhs_sync

// *** fhs_heater_model.sv ***
// roller thermal model with a bench override
`timescale 1ns/1ps
module fhs_heater_model (
  input wire logic mclk,
  input wire logic heater_switch,
  input wire logic hold,
  input wire logic [9:0] hold_t,
  output logic [9:0] temp
);
  logic [9:0] roll = 10'h014;
  // warms while heated, cools to room otherwise
  always @(negedge mclk) roll <= heater_switch ? roll + 10'h005 : roll - 10'(roll > 10'h014);
  assign temp = hold ? hold_t : roll;
endmodule // fhs_heater_model

// *** fhs_supervisor_assertions.sv ***
// assertion checker for the fixing heater supervisor
`timescale 1ns/1ps
module fhs_supervisor_assertions #(
  parameter int SAMPLE_CYC = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [9:0] fixing_thermistor,
  input wire logic printing,
  input wire logic cover_service_switch,
  input wire logic heater_switch,
  input wire logic heater_fault_drive_n,
  input wire logic ready,
  input wire logic [7:0] status_code
);
  // windows assume the short sample period
  default clocking @(posedge mclk); endclocking
  default disable iff (reset || SAMPLE_CYC > 4);
  sequence hot_s; (fixing_thermistor > 10'h0e6)[*8]; endsequence
  sequence cool_s; (fixing_thermistor < 10'h08c)[*8]; endsequence
  code_drive_a: assert property (status_code == (heater_fault_drive_n ? 8'h00 : 8'h32)) else $error("code and drive differ");
  fault_latch_a: assert property (!heater_fault_drive_n |=> !heater_fault_drive_n && status_code == 8'h32)
    else $error("fault dropped");
  fault_heat_a: assert property (!heater_fault_drive_n |-> !heater_switch && !ready) else $error("heat in fault");
  cover_off_a: assert property (cover_service_switch[*5] |-> !heater_switch) else $error("heat with cover");
  over_temp_a: assert property (hot_s |-> status_code == 8'h32) else $error("no over fault");
  under_temp_a: assert property (ready ##1 cool_s |-> !heater_fault_drive_n) else $error("no under fault");
  standby_off_a: assert property ((!printing && fixing_thermistor == 10'h0aa)[*8] |-> !heater_switch)
    else $error("standby heat");
  print_on_a: assert property ((printing && !cover_service_switch && fixing_thermistor == 10'h0aa)[*8]
    ##0 heater_fault_drive_n |-> heater_switch) else $error("print no heat");
endmodule // fhs_supervisor_assertions
bind fhs_supervisor fhs_supervisor_assertions #(.SAMPLE_CYC(SAMPLE_CYC)) fhs_supervisor_assertions_i (
  .mclk(mclk), .reset(reset), .fixing_thermistor(fixing_thermistor), .printing(printing),
  .cover_service_switch(cover_service_switch), .heater_switch(heater_switch),
  .heater_fault_drive_n(heater_fault_drive_n), .ready(ready), .status_code(status_code));

// *** fhs_supervisor_tb.sv ***
// self-checking bench for the fixing heater supervisor
`timescale 1ns/1ps
module fhs_supervisor_tb;
  logic mclk = 0, reset = 1, printing = 0, cover_service_switch = 0, hold = 1;
  logic heater_switch, heater_fault_drive_n, ready;
  logic [9:0] hold_t = 10'h014, temp, t;
  logic [7:0] status_code;
  logic [31:0] seed = 99887;
  int err_total = 0, compares = 0, i;
  fhs_supervisor #(.SAMPLE_CYC(4), .TICKS_PER_S(2), .WARM1_S(3), .WARM2_S(6)) fhs_supervisor_i (
    .mclk(mclk), .reset(reset), .fixing_thermistor(temp), .printing(printing),
    .cover_service_switch(cover_service_switch), .heater_switch(heater_switch),
    .heater_fault_drive_n(heater_fault_drive_n), .ready(ready), .status_code(status_code));
  fhs_heater_model fhs_heater_model_i (.mclk(mclk), .heater_switch(heater_switch), .hold(hold),
    .hold_t(hold_t), .temp(temp));
  initial forever #25 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // heater wanted below the active setpoint
  function automatic logic exp_heat(input logic [9:0] v, input logic p);
    return v < (p ? 10'h0b4 : 10'h0a5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic restart(input logic h, input logic [9:0] v);
    reset = 1;
    hold = h;
    hold_t = v;
    run(2);
    reset = 0;
  endtask
  task tally_and_finish;
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    restart(0, 10'h014);
    for (i = 0; i < 200 && ready !== 1'b1; i++) run(1);
    chk(8'(ready), 8'h01);
    // random held temperatures, two fixed corners first
    for (i = 0; i < 24; i++) begin
      seed = xs(seed);
      t = (i < 2) ? 10'h0aa : 10'h08d + 10'(seed % 89);
      hold = 1;
      hold_t = (t == 10'h0a5 || t == 10'h0b4) ? t + 10'h001 : t;
      printing = (i < 2) ? i[0] : seed[7];
      run(12);
      chk(8'(heater_switch), 8'(exp_heat(hold_t, printing)));
    end
    cover_service_switch = 1;
    hold_t = 10'h096;
    run(12);
    chk(8'(heater_switch), 8'h00);
    cover_service_switch = 0;
    run(12);
    chk(8'(heater_switch), 8'h01);
    hold_t = 10'h082;
    run(12);
    chk(status_code, 8'h32);
    chk(8'(heater_fault_drive_n), 8'h00);
    hold_t = 10'h064;
    run(12);
    chk(8'({ready, heater_switch, heater_fault_drive_n}), 8'h00);
    restart(1, 10'h0f0);
    run(12);
    chk(status_code, 8'h32);
    restart(1, 10'h014);
    run(16);
    chk(status_code, 8'h00);
    run(24);
    chk(status_code, 8'h32);
    restart(1, 10'h064);
    run(40);
    chk(status_code, 8'h00);
    run(24);
    chk(status_code, 8'h32);
    tally_and_finish;
  end
endmodule // fhs_supervisor_tb
